// file: escs_params.svh
`ifndef ESCS_PARAMS_SVH
`define ESCS_PARAMS_SVH
// ****************************************
// register offsets (byte addresses)
// ****************************************
`define ESCS_OFF_CTRL 12'h000
`define ESCS_OFF_STATUS 12'h004
`define ESCS_OFF_IRQ_STAT 12'h008
`define ESCS_OFF_IRQ_MASK 12'h00c
`define ESCS_OFF_DV_DELAY 12'h010
`define ESCS_OFF_IGN_TIME 12'h014
`define ESCS_OFF_SPARK_TIME 12'h018
`define ESCS_OFF_HE_TIME 12'h01c
// ****************************************
// control fields (write one to pulse)
// ****************************************
`define ESCS_CTRL_BYPASS 0
`define ESCS_CTRL_START 1
`define ESCS_CTRL_CUTOFF 2
// ****************************************
// interrupt status fields
// ****************************************
`define ESCS_IRQ_READY 0
`define ESCS_IRQ_MAINSTAGE 1
`define ESCS_IRQ_CUTOFF 2
`define ESCS_IRQ_FAULT 3
`define ESCS_IRQ_W 4
// ****************************************
// reset values of timer lengths (cycles)
// ****************************************
`define ESCS_DV_DELAY_RST 32'h0000_0400
`define ESCS_IGN_TIME_RST 32'h0000_0800
`define ESCS_SPARK_TIME_RST 32'h0000_1000
`define ESCS_HE_TIME_RST 32'h0000_0400
// ****************************************
// axi responses
// ****************************************
`define ESCS_RESP_OKAY 2'h0
`define ESCS_RESP_SLVERR 2'h2
`endif

// file: escs_pkg.sv
package escs_pkg;
	// sequencer phases, gray coded along start path
	typedef enum logic [2:0] {
		ESCS_IDLE = 3'h0,
		ESCS_READY = 3'h1,
		ESCS_DV_WAIT = 3'h3,
		ESCS_IGNITION = 3'h2,
		ESCS_SPARK = 3'h6,
		ESCS_MAIN = 3'h7,
		ESCS_CUTOFF = 3'h5
	} escs_state_t;

	// valve and exciter outputs
	typedef struct packed {
		logic spark_igniter_torch;
		logic spark_gas_generator;
		logic helium_ctrl;
		logic ignition_ctrl;
		logic start_discharge_valve;
		logic mainstage_ctrl;
	} escs_valves_t;

	// interlock inputs
	typedef struct packed {
		logic fuel_inj_temp_ok;
		logic start_tank_depress;
		logic thrust_ok_a;
		logic thrust_ok_b;
	} escs_sense_t;
endpackage : escs_pkg

// file: escs_timer.sv
`timescale 1ns/1ps
`default_nettype none
// ****************************************
// one-shot down counter, expiry pulse
// ****************************************
module escs_timer
	import escs_pkg::*;
(
	// clock and reset
	input wire logic aclk,
	input wire logic aresetn,
	// control
	input wire logic load,
	input wire logic abort,
	input wire logic [31:0] length,
	// status
	output logic running,
	output logic expired
);
	logic [31:0] cnt_ff;
	logic run_ff;
	logic exp_ff;

	// a length of zero still runs one cycle so expiry is never skipped
	always_ff @(posedge aclk) begin
		if (!aresetn || abort) begin
			cnt_ff <= 32'h0;
			run_ff <= 1'b0;
			exp_ff <= 1'b0;
		end else if (load) begin
			cnt_ff <= (length == 32'h0) ? 32'h1 : length;
			run_ff <= 1'b1;
			exp_ff <= 1'b0;
		end else if (run_ff && cnt_ff == 32'h1) begin
			cnt_ff <= 32'h0;
			run_ff <= 1'b0;
			exp_ff <= 1'b1;
		end else begin
			if (run_ff) begin
				cnt_ff <= cnt_ff - 32'h1;
			end
			exp_ff <= 1'b0;
		end
	end

	assign running = run_ff;
	assign expired = exp_ff;
endmodule : escs_timer
`default_nettype wire

// file: escs_sequencer.sv
// Chosen here: the AXI4-Lite slave port and the address map.
`timescale 1ns/1ps
`default_nettype none
`include "escs_params.svh"
module escs_sequencer
	import escs_pkg::*;
(
	// clock and reset
	input wire logic aclk,
	input wire logic aresetn,
	// axi4-lite write address
	input wire logic [11:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	// axi4-lite write data
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	// axi4-lite write response
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	// axi4-lite read address
	input wire logic [11:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	// axi4-lite read data
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	// engine interlocks and external cutoff requests
	input wire escs_sense_t sense,
	input wire logic ext_cutoff_req,
	input wire logic reset_cond_ok,
	// engine outputs
	output escs_valves_t valves,
	output logic engine_ready,
	output logic irq
);
	// ****************************************
	// register bus
	// ****************************************
	logic [11:0] awaddr_ff;
	logic aw_held_ff;
	logic [31:0] wdata_ff;
	logic [3:0] wstrb_ff;
	logic w_held_ff;
	logic bvalid_ff;
	logic [1:0] bresp_ff;
	logic rvalid_ff;
	logic [31:0] rdata_ff;
	logic [1:0] rresp_ff;
	logic wr_fire;
	logic [31:0] dv_len_ff;
	logic [31:0] ign_len_ff;
	logic [31:0] spk_len_ff;
	logic [31:0] he_len_ff;
	logic [`ESCS_IRQ_W-1:0] irq_stat_ff;
	logic [`ESCS_IRQ_W-1:0] irq_mask_ff;
	logic cmd_bypass;
	logic cmd_start;
	logic cmd_cutoff;

	// merge a write with its byte enables
	function automatic logic [31:0] merge_be(input logic [31:0] old, input logic [31:0] nw,
		input logic [3:0] be);
		logic [31:0] r;
		r = old;
		for (int i = 0; i < 4; i++) begin
			if (be[i]) begin
				r[i*8 +: 8] = nw[i*8 +: 8];
			end
		end
		return r;
	endfunction : merge_be

	// address and data may come in either order; accept each once
	assign s_axi_awready = !aw_held_ff && !bvalid_ff;
	assign s_axi_wready = !w_held_ff && !bvalid_ff;
	assign wr_fire = aw_held_ff && w_held_ff && !bvalid_ff;

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			aw_held_ff <= 1'b0;
			awaddr_ff <= 12'h0;
		end else if (s_axi_awvalid && s_axi_awready) begin
			aw_held_ff <= 1'b1;
			awaddr_ff <= s_axi_awaddr;
		end else if (wr_fire) begin
			aw_held_ff <= 1'b0;
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			w_held_ff <= 1'b0;
			wdata_ff <= 32'h0;
			wstrb_ff <= 4'h0;
		end else if (s_axi_wvalid && s_axi_wready) begin
			w_held_ff <= 1'b1;
			wdata_ff <= s_axi_wdata;
			wstrb_ff <= s_axi_wstrb;
		end else if (wr_fire) begin
			w_held_ff <= 1'b0;
		end
	end

	// write response; unmapped offsets answer slverr
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			bvalid_ff <= 1'b0;
			bresp_ff <= `ESCS_RESP_OKAY;
		end else if (wr_fire) begin
			bvalid_ff <= 1'b1;
			bresp_ff <= (awaddr_ff[11:5] == 7'h0 && awaddr_ff[1:0] == 2'h0) ?
				`ESCS_RESP_OKAY : `ESCS_RESP_SLVERR;
		end else if (s_axi_bready) begin
			bvalid_ff <= 1'b0;
		end
	end
	assign s_axi_bvalid = bvalid_ff;
	assign s_axi_bresp = bresp_ff;

	// command pulses from the control register
	assign cmd_bypass = wr_fire && awaddr_ff == `ESCS_OFF_CTRL && wstrb_ff[0] &&
		wdata_ff[`ESCS_CTRL_BYPASS];
	assign cmd_start = wr_fire && awaddr_ff == `ESCS_OFF_CTRL && wstrb_ff[0] &&
		wdata_ff[`ESCS_CTRL_START];
	assign cmd_cutoff = wr_fire && awaddr_ff == `ESCS_OFF_CTRL && wstrb_ff[0] &&
		wdata_ff[`ESCS_CTRL_CUTOFF];

	// timer lengths, programmable cycle counts
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			dv_len_ff <= `ESCS_DV_DELAY_RST;
			ign_len_ff <= `ESCS_IGN_TIME_RST;
			spk_len_ff <= `ESCS_SPARK_TIME_RST;
			he_len_ff <= `ESCS_HE_TIME_RST;
			irq_mask_ff <= '0;
		end else if (wr_fire) begin
			unique case (awaddr_ff)
				`ESCS_OFF_DV_DELAY: dv_len_ff <= merge_be(dv_len_ff, wdata_ff, wstrb_ff);
				`ESCS_OFF_IGN_TIME: ign_len_ff <= merge_be(ign_len_ff, wdata_ff, wstrb_ff);
				`ESCS_OFF_SPARK_TIME: spk_len_ff <= merge_be(spk_len_ff, wdata_ff, wstrb_ff);
				`ESCS_OFF_HE_TIME: he_len_ff <= merge_be(he_len_ff, wdata_ff, wstrb_ff);
				`ESCS_OFF_IRQ_MASK: begin
					if (wstrb_ff[0]) begin
						irq_mask_ff <= wdata_ff[`ESCS_IRQ_W-1:0];
					end
				end
				default: begin
				end
			endcase
		end
	end

	// ****************************************
	// sequencer
	// ****************************************
	escs_state_t state_ff;
	escs_state_t nxt_state;
	logic thrust_ok;
	logic ext_cut_armed;
	logic dv_exp;
	logic ign_exp;
	logic spk_exp;
	logic he_exp;
	logic he_run;
	logic go_cutoff;
	logic dv_load;
	logic ign_load;
	logic spk_load;
	logic seq_abort;
	logic sparks_ff;
	logic helium_ff;
	logic fault_ev;

	assign thrust_ok = sense.thrust_ok_a || sense.thrust_ok_b;
	// the thrust switches inhibit outside cutoffs; dropping both unmasks them
	assign ext_cut_armed = ext_cutoff_req && !thrust_ok;

	// fault cutoff causes, one per running phase; none in dv_wait
	always_comb begin
		fault_ev = 1'b0;
		unique case (state_ff)
			ESCS_IGNITION: fault_ev = ign_exp && !sense.start_tank_depress;
			ESCS_SPARK: fault_ev = spk_exp && !thrust_ok;
			ESCS_MAIN: fault_ev = !thrust_ok;
			default: fault_ev = 1'b0;
		endcase
	end
	assign go_cutoff = state_ff != ESCS_IDLE && state_ff != ESCS_READY && state_ff != ESCS_CUTOFF &&
		(fault_ev || cmd_cutoff || ext_cut_armed);

	always_comb begin
		nxt_state = state_ff;
		unique case (state_ff)
			ESCS_IDLE: if (cmd_bypass && reset_cond_ok) nxt_state = ESCS_READY;
			ESCS_READY: if (cmd_start) nxt_state = ESCS_DV_WAIT;
			ESCS_DV_WAIT: if (dv_exp || !sense.fuel_inj_temp_ok) begin
				if (dv_exp && sense.fuel_inj_temp_ok) nxt_state = ESCS_IGNITION;
			end
			ESCS_IGNITION: if (sense.start_tank_depress) nxt_state = ESCS_SPARK;
			ESCS_SPARK: if (spk_exp && thrust_ok) nxt_state = ESCS_MAIN;
			ESCS_MAIN: nxt_state = ESCS_MAIN;
			ESCS_CUTOFF: if (!he_run) nxt_state = reset_cond_ok ? ESCS_READY : ESCS_IDLE;
		endcase
		if (go_cutoff) begin
			nxt_state = ESCS_CUTOFF;
		end
		// bypass skips the cutoff phase and goes straight to ready, or to idle without reset_cond_ok
		if (cmd_bypass && state_ff != ESCS_IDLE && state_ff != ESCS_CUTOFF) begin
			nxt_state = reset_cond_ok ? ESCS_READY : ESCS_IDLE;
		end
	end

	// delay in dv_wait holds until expiry latched; expiry pulse is remembered
	logic dv_done_ff;
	always_ff @(posedge aclk) begin
		if (!aresetn || state_ff != ESCS_DV_WAIT) begin
			dv_done_ff <= 1'b0;
		end else if (dv_exp) begin
			dv_done_ff <= 1'b1;
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			state_ff <= ESCS_IDLE;
		end else if (state_ff == ESCS_DV_WAIT && dv_done_ff && sense.fuel_inj_temp_ok && !go_cutoff
			&& !cmd_bypass) begin
			state_ff <= ESCS_IGNITION;
		end else begin
			state_ff <= nxt_state;
		end
	end

	assign dv_load = state_ff == ESCS_READY && cmd_start;
	assign ign_load = state_ff == ESCS_DV_WAIT && nxt_state != ESCS_CUTOFF &&
		(dv_exp || dv_done_ff) && sense.fuel_inj_temp_ok && !cmd_bypass;
	assign spk_load = state_ff == ESCS_IGNITION && nxt_state == ESCS_SPARK;
	assign seq_abort = go_cutoff || cmd_bypass;

	escs_timer u_dv_timer (.aclk(aclk), .aresetn(aresetn), .load(dv_load), .abort(seq_abort),
		.length(dv_len_ff), .running(), .expired(dv_exp));
	escs_timer u_ign_timer (.aclk(aclk), .aresetn(aresetn), .load(ign_load), .abort(seq_abort),
		.length(ign_len_ff), .running(), .expired(ign_exp));
	escs_timer u_spk_timer (.aclk(aclk), .aresetn(aresetn), .load(spk_load), .abort(seq_abort),
		.length(spk_len_ff), .running(), .expired(spk_exp));
	escs_timer u_he_timer (.aclk(aclk), .aresetn(aresetn), .load(go_cutoff), .abort(1'b0),
		.length(he_len_ff), .running(he_run), .expired(he_exp));

	// spark exciters on at start, off at sparks timer expiry or cutoff
	always_ff @(posedge aclk) begin
		if (!aresetn || seq_abort || spk_exp) begin
			sparks_ff <= 1'b0;
		end else if (dv_load) begin
			sparks_ff <= 1'b1;
		end
	end

	// helium stays up through the cutoff until its own timer runs out
	always_ff @(posedge aclk) begin
		if (!aresetn || he_exp || (cmd_bypass && !go_cutoff)) begin
			helium_ff <= 1'b0;
		end else if (dv_load) begin
			helium_ff <= 1'b1;
		end
	end

	// registered valve outputs derived from phase and the spark and helium flags
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			valves <= '0;
			engine_ready <= 1'b0;
		end else begin
			valves.spark_igniter_torch <= sparks_ff;
			valves.spark_gas_generator <= sparks_ff;
			valves.helium_ctrl <= helium_ff;
			valves.ignition_ctrl <= state_ff inside {ESCS_DV_WAIT, ESCS_IGNITION, ESCS_SPARK,
				ESCS_MAIN};
			valves.start_discharge_valve <= state_ff == ESCS_IGNITION;
			valves.mainstage_ctrl <= state_ff inside {ESCS_SPARK, ESCS_MAIN};
			engine_ready <= state_ff == ESCS_READY;
		end
	end

	// ****************************************
	// interrupts and read path
	// ****************************************
	logic [`ESCS_IRQ_W-1:0] irq_ev;
	logic [`ESCS_IRQ_W-1:0] irq_clr;
	assign irq_ev = {fault_ev && go_cutoff, go_cutoff, state_ff == ESCS_SPARK &&
		nxt_state == ESCS_MAIN, state_ff != ESCS_READY && nxt_state == ESCS_READY};
	assign irq_clr = (wr_fire && awaddr_ff == `ESCS_OFF_IRQ_STAT && wstrb_ff[0]) ?
		wdata_ff[`ESCS_IRQ_W-1:0] : '0;

	// a new event in the clearing cycle wins
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			irq_stat_ff <= '0;
		end else begin
			irq_stat_ff <= (irq_stat_ff & ~irq_clr) | irq_ev;
		end
	end
	assign irq = |(irq_stat_ff & irq_mask_ff);

	assign s_axi_arready = !rvalid_ff;
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			rvalid_ff <= 1'b0;
			rdata_ff <= 32'h0;
			rresp_ff <= `ESCS_RESP_OKAY;
		end else if (s_axi_arvalid && s_axi_arready) begin
			rvalid_ff <= 1'b1;
			rresp_ff <= `ESCS_RESP_OKAY;
			unique case (s_axi_araddr)
				`ESCS_OFF_CTRL: rdata_ff <= 32'h0;
				`ESCS_OFF_STATUS: rdata_ff <= {19'h0, sense, valves, state_ff};
				`ESCS_OFF_IRQ_STAT: rdata_ff <= {28'h0, irq_stat_ff};
				`ESCS_OFF_IRQ_MASK: rdata_ff <= {28'h0, irq_mask_ff};
				`ESCS_OFF_DV_DELAY: rdata_ff <= dv_len_ff;
				`ESCS_OFF_IGN_TIME: rdata_ff <= ign_len_ff;
				`ESCS_OFF_SPARK_TIME: rdata_ff <= spk_len_ff;
				`ESCS_OFF_HE_TIME: rdata_ff <= he_len_ff;
				default: begin
					rdata_ff <= 32'h0;
					rresp_ff <= `ESCS_RESP_SLVERR;
				end
			endcase
		end else if (s_axi_rready) begin
			rvalid_ff <= 1'b0;
		end
	end
	assign s_axi_rvalid = rvalid_ff;
	assign s_axi_rdata = rdata_ff;
	assign s_axi_rresp = rresp_ff;
endmodule : escs_sequencer
`default_nettype wire

// file: escs_seq_props.sv
`timescale 1ns/1ps
`default_nettype none
// ****************************************
// sequencer output checks
// ****************************************
module escs_seq_props
	import escs_pkg::*;
(
	// clock and reset
	input wire logic aclk,
	input wire logic aresetn,
	// watched ports
	input wire escs_sense_t sense,
	input wire logic ext_cutoff_req,
	input wire escs_valves_t valves,
	input wire logic engine_ready
);
	default clocking cb @(posedge aclk);
	endclocking
	default disable iff (!aresetn);
	// either switch counts as thrust
	wire logic thr_any;
	assign thr_any = sense.thrust_ok_a | sense.thrust_ok_b;
	a_ready_quiet:
		assert property (engine_ready |-> !valves.ignition_ctrl && !valves.mainstage_ctrl)
		else $error("valves active while ready");
	a_start_together:
		assert property ($rose(valves.ignition_ctrl) |-> valves.helium_ctrl
			&& valves.spark_igniter_torch && !valves.mainstage_ctrl)
		else $error("start outputs not together");
	a_dv_needs_temp:
		assert property ($rose(valves.start_discharge_valve) |-> valves.ignition_ctrl
			&& $past(sense.fuel_inj_temp_ok, 2))
		else $error("discharge valve without temp ok");
	a_main_dv_swap:
		assert property ($rose(valves.mainstage_ctrl) |-> $fell(valves.start_discharge_valve)
			&& valves.spark_igniter_torch)
		else $error("mainstage and discharge not swapped");
	a_spark_pair:
		assert property (valves.spark_igniter_torch == valves.spark_gas_generator)
		else $error("spark exciters differ");
	a_thrust_loss:
		assert property (valves.mainstage_ctrl && !valves.spark_igniter_torch && !thr_any
			|-> ##[1:4] !valves.mainstage_ctrl)
		else $error("no cutoff on thrust loss");
	a_cut_drops:
		assert property ($fell(valves.mainstage_ctrl) |-> !valves.ignition_ctrl
			&& valves.helium_ctrl)
		else $error("cutoff output pattern wrong");
	a_ext_unmask:
		assert property (valves.ignition_ctrl && ext_cutoff_req && !thr_any
			|-> ##[1:4] !valves.ignition_ctrl)
		else $error("external cutoff ignored");
	a_main_steady:
		assert property (valves.mainstage_ctrl |-> valves.helium_ctrl && valves.ignition_ctrl
			&& !valves.start_discharge_valve)
		else $error("mainstage outputs unsteady");
	// main scenarios reached
	c_ready: cover property ($rose(engine_ready));
	c_main: cover property ($fell(valves.spark_igniter_torch) && valves.mainstage_ctrl);
	c_he_off: cover property ($fell(valves.helium_ctrl));
endmodule : escs_seq_props
bind escs_sequencer escs_seq_props i_props (.aclk(aclk), .aresetn(aresetn), .sense(sense),
	.ext_cutoff_req(ext_cutoff_req), .valves(valves), .engine_ready(engine_ready));
`default_nettype wire

// file: escs_fc_model.sv
`timescale 1ns/1ps
`default_nettype none
// ****************************************
// flight computer bus master
// ****************************************
module escs_fc_model
	import escs_pkg::*;
(
	// clock
	input wire logic aclk,
	// write side
	output logic [11:0] s_axi_awaddr,
	output logic s_axi_awvalid,
	input wire logic s_axi_awready,
	output logic [31:0] s_axi_wdata,
	output logic [3:0] s_axi_wstrb,
	output logic s_axi_wvalid,
	input wire logic s_axi_wready,
	input wire logic [1:0] s_axi_bresp,
	input wire logic s_axi_bvalid,
	output logic s_axi_bready,
	// read side
	output logic [11:0] s_axi_araddr,
	output logic s_axi_arvalid,
	input wire logic s_axi_arready,
	input wire logic [31:0] s_axi_rdata,
	input wire logic [1:0] s_axi_rresp,
	input wire logic s_axi_rvalid,
	output logic s_axi_rready
);
	// responses always accepted, so ready never toggles between transfers
	initial begin
		s_axi_awaddr = 12'h000;
		s_axi_awvalid = 1'b0;
		s_axi_wdata = 32'h0;
		s_axi_wstrb = 4'hf;
		s_axi_wvalid = 1'b0;
		s_axi_bready = 1'b1;
		s_axi_araddr = 12'h000;
		s_axi_arvalid = 1'b0;
		s_axi_rready = 1'b1;
	end
	// one write, each channel dropped on its own handshake
	task automatic wr(input logic [11:0] a, input logic [31:0] d, output logic [1:0] r);
		logic aw_p;
		logic w_p;
		aw_p = 1'b1;
		w_p = 1'b1;
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		do begin
			@(posedge aclk);
			if (aw_p && s_axi_awready) begin
				aw_p = 1'b0;
				s_axi_awvalid <= 1'b0;
			end
			if (w_p && s_axi_wready) begin
				w_p = 1'b0;
				s_axi_wvalid <= 1'b0;
			end
		end while (aw_p || w_p || !s_axi_bvalid);
		r = s_axi_bresp;
	endtask : wr
	// one read
	task automatic rd(input logic [11:0] a, output logic [31:0] d, output logic [1:0] r);
		logic ar_p;
		ar_p = 1'b1;
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		do begin
			@(posedge aclk);
			if (ar_p && s_axi_arready) begin
				ar_p = 1'b0;
				s_axi_arvalid <= 1'b0;
			end
		end while (ar_p || !s_axi_rvalid);
		d = s_axi_rdata;
		r = s_axi_rresp;
	endtask : rd
endmodule : escs_fc_model
`default_nettype wire

// file: tb_top.sv
`timescale 1ns/1ps
`default_nettype none
`include "escs_params.svh"
module tb_top
	import escs_pkg::*;
;
	logic aclk = 1'b0;
	logic aresetn = 1'b0;
	logic [11:0] s_axi_awaddr, s_axi_araddr;
	logic [31:0] s_axi_wdata, s_axi_rdata;
	logic [3:0] s_axi_wstrb;
	logic [1:0] s_axi_bresp, s_axi_rresp;
	logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
	logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
	escs_sense_t sense = 4'h0;
	logic ext_cutoff_req = 1'b0;
	logic reset_cond_ok = 1'b0;
	escs_valves_t valves;
	logic engine_ready, irq;
	int fails = 0;
	int checks = 0;
	logic [31:0] rst_vals [4] = '{`ESCS_DV_DELAY_RST, `ESCS_IGN_TIME_RST,
		`ESCS_SPARK_TIME_RST, `ESCS_HE_TIME_RST};
	escs_sequencer i_escs_sequencer (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid,
		.s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
		.s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
		.s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .sense, .ext_cutoff_req, .reset_cond_ok,
		.valves, .engine_ready, .irq);
	escs_fc_model i_fc (.aclk, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
		.s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
		.s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
		.s_axi_rready);
	// 200 MHz clock
	always #2.5 aclk = ~aclk;
	// ****************************************
	// checking helpers
	// ****************************************
	task automatic chk(input string n, input logic [31:0] s, input logic [31:0] e);
		checks++;
		if (s !== e) begin
			fails++;
			$display("CHECK FAILED %s expected %h seen %h", n, e, s);
		end
	endtask : chk
	// valve pattern each settled phase must show
	function automatic escs_valves_t exp_valves(input escs_state_t ph);
		case (ph)
			ESCS_DV_WAIT: return 6'h3c;
			ESCS_IGNITION: return 6'h3e;
			ESCS_SPARK: return 6'h3d;
			ESCS_MAIN: return 6'h0d;
			default: return 6'h00;
		endcase
	endfunction : exp_valves
	// poll status, then let the output registers catch up before comparing
	task automatic wait_phase(input escs_state_t ph);
		logic [31:0] d;
		logic [1:0] r;
		int n;
		n = 0;
		do begin
			i_fc.rd(`ESCS_OFF_STATUS, d, r);
			n++;
		end while (d[2:0] !== ph && n < 300);
		repeat (2) @(posedge aclk);
		chk("phase", 32'(d[2:0]), 32'(ph));
		chk("valves", 32'(valves), 32'(exp_valves(ph)));
	endtask : wait_phase
	task automatic conclude;
		if (fails == 0 && checks > 0) $display("Run complete: PASS");
		else $display("Run complete: FAIL");
		$finish;
	endtask : conclude
	// ****************************************
	// one start attempt; k picks the fault
	// ****************************************
	task automatic attempt(input int k);
		logic [31:0] lens [4];
		logic [1:0] r;
		logic dep;
		logic thr;
		logic tmp;
		dep = (k != 1);
		thr = (k != 2);
		tmp = (k != 3);
		lens[0] = 8 + $urandom_range(7);
		lens[1] = 30 + $urandom_range(10);
		lens[2] = 40 + $urandom_range(20);
		lens[3] = 8 + $urandom_range(7);
		for (int i = 0; i < 4; i++) i_fc.wr(`ESCS_OFF_DV_DELAY + 12'(4 * i), lens[i], r);
		sense <= {tmp, 3'h0};
		ext_cutoff_req <= 1'b0;
		i_fc.wr(`ESCS_OFF_CTRL, 32'h1, r);
		wait_phase(ESCS_READY);
		chk("engine_ready", 32'(engine_ready), 32'h1);
		i_fc.wr(`ESCS_OFF_CTRL, 32'h2, r);
		repeat (lens[0] - 4) @(posedge aclk);
		chk("dv early", 32'(valves.start_discharge_valve), 32'h0);
		if (!tmp) begin
			repeat (30) @(posedge aclk);
			wait_phase(ESCS_DV_WAIT);
			ext_cutoff_req <= 1'b1;
			wait_phase(ESCS_READY);
			return;
		end
		wait_phase(ESCS_IGNITION);
		sense.start_tank_depress <= dep;
		wait_phase(dep ? ESCS_SPARK : ESCS_READY);
		if (!dep) return;
		sense.thrust_ok_a <= thr;
		wait_phase(thr ? ESCS_MAIN : ESCS_READY);
		if (!thr) return;
		// masked request with one switch left must not stop the engine
		ext_cutoff_req <= 1'b1;
		sense[1:0] <= 2'h1;
		repeat (20) @(posedge aclk);
		wait_phase(ESCS_MAIN);
		sense[1:0] <= 2'h0;
		wait_phase(ESCS_READY);
		chk("ready after cutoff", 32'(engine_ready), 32'h1);
	endtask : attempt
	// main sequence
	initial begin
		logic [31:0] d;
		logic [1:0] r;
		void'($urandom(2));
		repeat (6) @(posedge aclk);
		aresetn <= 1'b1;
		@(posedge aclk);
		for (int i = 0; i < 4; i++) begin
			i_fc.rd(`ESCS_OFF_DV_DELAY + 12'(4 * i), d, r);
			chk("timer default", d, rst_vals[i]);
		end
		i_fc.rd(12'h100, d, r);
		chk("unmapped resp", 32'(r), 32'(`ESCS_RESP_SLVERR));
		i_fc.wr(`ESCS_OFF_CTRL, 32'h1, r);
		repeat (4) @(posedge aclk);
		chk("bypass refused", 32'(engine_ready), 32'h0);
		reset_cond_ok <= 1'b1;
		i_fc.wr(`ESCS_OFF_CTRL, 32'h2, r);
		repeat (4) @(posedge aclk);
		chk("start refused", 32'(valves), 32'h0);
		i_fc.wr(`ESCS_OFF_IRQ_MASK, 32'h1, r);
		i_fc.wr(`ESCS_OFF_CTRL, 32'h1, r);
		wait_phase(ESCS_READY);
		chk("irq raised", 32'(irq), 32'h1);
		i_fc.wr(`ESCS_OFF_IRQ_MASK, 32'h0, r);
		chk("irq masked", 32'(irq), 32'h0);
		i_fc.wr(`ESCS_OFF_IRQ_STAT, 32'hf, r);
		i_fc.wr(`ESCS_OFF_IRQ_MASK, 32'hf, r);
		chk("irq cleared", 32'(irq), 32'h0);
		attempt(0);
		// ready, mainstage, cutoff and fault events all latched by the full run
		i_fc.rd(`ESCS_OFF_IRQ_STAT, d, r);
		chk("irq events", d, 32'hf);
		chk("irq pending", 32'(irq), 32'h1);
		i_fc.wr(`ESCS_OFF_IRQ_STAT, 32'hf, r);
		for (int k = 1; k < 4; k++) attempt(k);
		conclude();
	end
	// hang guard, far beyond the longest run
	initial begin
		repeat (80000) @(posedge aclk);
		fails++;
		conclude();
	end
endmodule : tb_top
`default_nettype wire
